// ==== dpm_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpm_peer (
  input wire logic mclk,
  input wire logic [1:0] drv_en,
  input wire logic [1:0] drv_val,
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe,
  input wire logic [1:0] pad_pu,
  output logic [1:0] pin_lvl,
  output logic latched_bit
);
  logic churn_ff = 1'b0;
  // a floating pin must not look stable, so it shows a level that flips every cycle
  always @(posedge mclk)
  begin
    churn_ff <= ~churn_ff;
  end
  // wire level: device drive wins, then the peer drive, then the pull-up
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (pad_oe[i])
        pin_lvl[i] = pad_out[i];
      else if (drv_en[i])
        pin_lvl[i] = drv_val[i];
      else if (pad_pu[i])
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = churn_ff ^ i[0];
    end
  end
  // as spi slave, take the data line (pin b) on the rising clock (pin a)
  always @(posedge pin_lvl[0])
  begin
    latched_bit <= pin_lvl[1];
  end
endmodule // dpm_peer
`default_nettype wire

// ==== dpm_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_cell (
  input wire dpm_pkg::dpm_func_t func,
  input wire logic alt_sel,
  input wire logic spi_master,
  input wire logic spi_out,
  input wire logic tmr_out,
  input wire logic tmr_oe,
  input wire logic gpio_dir,
  input wire logic gpio_out,
  input wire logic pin_in,
  output logic pad_out,
  output logic pad_oe,
  output logic to_decoder,
  output logic to_timer,
  output logic to_spi,
  output logic to_gpio
);
  // routing of one phase pin; unselected cores see a quiet low input
  always_comb
  begin
    pad_out = 1'h0;
    pad_oe = 1'h0;
    to_decoder = 1'h0;
    to_timer = 1'h0;
    to_spi = 1'h0;
    to_gpio = 1'h0;
    if (alt_sel)
    begin
      // spi line: driven as master, sampled as slave
      // clock and data pass the same single flop, so the half-cycle lead survives
      pad_oe = spi_master;
      pad_out = spi_master & spi_out;
      to_spi = ~spi_master & pin_in;
    end
    else
    begin
      case (func)
        dpm_pkg::FN_DECODER:
        begin
          to_decoder = pin_in;
        end
        dpm_pkg::FN_TIMER:
        begin
          // timer channel owns direction
          pad_oe = tmr_oe;
          pad_out = tmr_out;
          to_timer = pin_in;
        end
        dpm_pkg::FN_GPIO:
        begin
          // per-pin direction
          pad_oe = gpio_dir;
          pad_out = gpio_out;
          to_gpio = pin_in;
        end
        default:
        begin
          // unconfigured pin stays an undriven input
          pad_oe = 1'h0;
        end
      endcase
    end
  end
endmodule // dpm_pin_cell
`default_nettype wire

// ==== dpm_pin_mux.sv ====
// What this block does
// - full variant: phase A pin leaves reset as decoder 1 phase A input.
// - full variant: phase B pin leaves reset as decoder 1 phase B input.
// - reduced variant: both phase pins leave reset unassigned until software configures them.
// - phase A alternate-select bit set routes spi 1 serial clock to phase A pin.
// - phase B alternate-select bit set routes spi 1 master-out line to phase B pin.
// - port C pull-up bit 0 clear turns off pull-up of phase A pin.
// - port C pull-up bit 1 clear turns off pull-up of phase B pin.
// - port E pull-up bit 7 clear turns off pull-up of spi 0 select pin.
// - port E bit 7 pin defaults to spi 0 active-low slave select after reset.
// - spi 1 clock pin drives out as master, is clock input as slave.
// - spi master leads each data bit half a clock before the latching edge.
// - spi 1 master-out pin is output as master, input as slave.
// - a pin assigned to gpio has its own programmable direction.
// - phase A pin feeds decoder 1 phase A when that function is selected and the phase A alternate-select bit is clear.
// - while reset is held phase pins are inputs with pull-ups enabled.
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_mux #(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] pin_func_write,
  input wire dpm_pkg::dpm_func_t pin_func_value,
  input wire logic ss0_func_write,
  input wire logic ss0_func_gpio,
  input wire logic phase_a_alt_select,
  input wire logic phase_b_alt_select,
  input wire logic spi1_master_mode,
  input wire logic spi1_serial_clock_out,
  input wire logic spi1_master_out_line_out,
  input wire logic [1:0] timer_b_out,
  input wire logic [1:0] timer_b_oe,
  input wire logic [1:0] port_c_dir,
  input wire logic [1:0] port_c_out,
  input wire logic [7:0] port_c_pullup_enable,
  input wire logic [7:0] port_e_pullup_enable,
  input wire logic port_e7_dir,
  input wire logic port_e7_out,
  input wire logic decoder1_phase_a_pin_in,
  input wire logic decoder1_phase_b_pin_in,
  input wire logic spi0_slave_select_pin_in,
  output logic decoder1_phase_a_pin_out,
  output logic decoder1_phase_a_pin_oe,
  output logic decoder1_phase_a_pin_pullup,
  output logic decoder1_phase_b_pin_out,
  output logic decoder1_phase_b_pin_oe,
  output logic decoder1_phase_b_pin_pullup,
  output logic spi0_slave_select_pin_out,
  output logic spi0_slave_select_pin_oe,
  output logic spi0_slave_select_pin_pullup,
  output logic decoder1_phase_a,
  output logic decoder1_phase_b,
  output logic [1:0] timer_b_in,
  output logic spi1_serial_clock_in,
  output logic spi1_master_out_line_in,
  output logic [1:0] port_c_in,
  output logic spi0_slave_select_n,
  output logic port_e7_in,
  output var dpm_pkg::dpm_func_t pin_func_a,
  output var dpm_pkg::dpm_func_t pin_func_b
);
  localparam dpm_pkg::dpm_func_t FUNC_RST = FULL_VARIANT ? dpm_pkg::FUNC_RST_FULL : dpm_pkg::FUNC_RST_REDUCED;

  typedef struct packed {
    dpm_pkg::dpm_func_t [1:0] func;
    logic ss0_gpio;
    logic [1:0] pad_out;
    logic [1:0] pad_oe;
    logic [1:0] pad_pu;
    logic ss_out;
    logic ss_oe;
    logic ss_pu;
    logic [1:0] dec;
    logic [1:0] tmr;
    logic [1:0] gpio;
    logic spi_clk;
    logic spi_mosi;
    logic ss_n;
    logic pe7_in;
  } dpm_state_t;

  dpm_state_t st_ff;
  dpm_state_t nxt_st;

  logic [1:0] pin_in_v;
  logic [1:0] alt_v;
  logic [1:0] spi_out_v;
  logic [1:0] pur_v;
  logic [1:0] c_pad_out;
  logic [1:0] c_pad_oe;
  logic [1:0] c_dec;
  logic [1:0] c_tmr;
  logic [1:0] c_spi;
  logic [1:0] c_gpio;
  logic s_pad_out;
  logic s_pad_oe;
  logic s_ss_n;
  logic s_gpio;

  // index 0 is the phase A pin, index 1 the phase B pin
  assign pin_in_v = {decoder1_phase_b_pin_in, decoder1_phase_a_pin_in};
  assign alt_v = {phase_b_alt_select, phase_a_alt_select};
  assign spi_out_v = {spi1_master_out_line_out, spi1_serial_clock_out};
  assign pur_v = {port_c_pullup_enable[dpm_pkg::PC_BIT_B], port_c_pullup_enable[dpm_pkg::PC_BIT_A]};

  // one routing cell per phase pin, each muxing decoder, timer, spi and gpio
  for (genvar i = 0; i < dpm_pkg::NUM_PHASE_PINS; i++)
  begin : g_pin
    dpm_pin_cell u_cell (
      .func(st_ff.func[i]),
      .alt_sel(alt_v[i]),
      .spi_master(spi1_master_mode),
      .spi_out(spi_out_v[i]),
      .tmr_out(timer_b_out[i]),
      .tmr_oe(timer_b_oe[i]),
      .gpio_dir(port_c_dir[i]),
      .gpio_out(port_c_out[i]),
      .pin_in(pin_in_v[i]),
      .pad_out(c_pad_out[i]),
      .pad_oe(c_pad_oe[i]),
      .to_decoder(c_dec[i]),
      .to_timer(c_tmr[i]),
      .to_spi(c_spi[i]),
      .to_gpio(c_gpio[i])
    );
  end

  dpm_ss0_cell u_ss0 (
    .gpio_sel(st_ff.ss0_gpio),
    .gpio_dir(port_e7_dir),
    .gpio_out(port_e7_out),
    .pin_in(spi0_slave_select_pin_in),
    .pad_out(s_pad_out),
    .pad_oe(s_pad_oe),
    .ss_n(s_ss_n),
    .to_gpio(s_gpio)
  );

  // next state; reset is folded in here so the flop process stays a plain copy
  always_comb
  begin
    nxt_st = st_ff;
    for (int i = 0; i < dpm_pkg::NUM_PHASE_PINS; i++)
    begin
      if (pin_func_write[i])
      begin
        nxt_st.func[i] = pin_func_value;
      end
    end
    if (ss0_func_write)
    begin
      nxt_st.ss0_gpio = ss0_func_gpio;
    end
    nxt_st.pad_out = c_pad_out;
    nxt_st.pad_oe = c_pad_oe;
    nxt_st.pad_pu = pur_v;
    nxt_st.ss_out = s_pad_out;
    nxt_st.ss_oe = s_pad_oe;
    nxt_st.ss_pu = port_e_pullup_enable[dpm_pkg::PE_BIT_SS];
    nxt_st.dec = c_dec;
    nxt_st.tmr = c_tmr;
    nxt_st.gpio = c_gpio;
    nxt_st.spi_clk = c_spi[0];
    nxt_st.spi_mosi = c_spi[1];
    nxt_st.ss_n = s_ss_n;
    nxt_st.pe7_in = s_gpio;
    if (rst)
    begin
      // pins float as pulled-up inputs while reset is held
      nxt_st = '0;
      nxt_st.func[0] = FUNC_RST;
      nxt_st.func[1] = FUNC_RST;
      nxt_st.ss0_gpio = dpm_pkg::SS0_GPIO_RST;
      nxt_st.pad_pu = {dpm_pkg::PULLUP_RST, dpm_pkg::PULLUP_RST};
      nxt_st.ss_pu = dpm_pkg::PULLUP_RST;
      nxt_st.ss_n = 1'h1;
    end
  end

  // single state register
  always_ff @(posedge mclk)
  begin
    st_ff <= nxt_st;
  end

  // every output is a bit of the state register
  assign decoder1_phase_a_pin_out = st_ff.pad_out[0];
  assign decoder1_phase_a_pin_oe = st_ff.pad_oe[0];
  assign decoder1_phase_a_pin_pullup = st_ff.pad_pu[0];
  assign decoder1_phase_b_pin_out = st_ff.pad_out[1];
  assign decoder1_phase_b_pin_oe = st_ff.pad_oe[1];
  assign decoder1_phase_b_pin_pullup = st_ff.pad_pu[1];
  assign spi0_slave_select_pin_out = st_ff.ss_out;
  assign spi0_slave_select_pin_oe = st_ff.ss_oe;
  assign spi0_slave_select_pin_pullup = st_ff.ss_pu;
  assign decoder1_phase_a = st_ff.dec[0];
  assign decoder1_phase_b = st_ff.dec[1];
  assign timer_b_in = st_ff.tmr;
  assign spi1_serial_clock_in = st_ff.spi_clk;
  assign spi1_master_out_line_in = st_ff.spi_mosi;
  assign port_c_in = st_ff.gpio;
  assign spi0_slave_select_n = st_ff.ss_n;
  assign port_e7_in = st_ff.pe7_in;
  assign pin_func_a = st_ff.func[0];
  assign pin_func_b = st_ff.func[1];

  // checks on the routing; reset behaviour is checked with reset enabled
  default clocking cb @(posedge mclk);
  endclocking

  sequence seq_spi_master_a;
    phase_a_alt_select && spi1_master_mode;
  endsequence

  sequence seq_spi_slave_b;
    phase_b_alt_select && !spi1_master_mode;
  endsequence

  sequence seq_decoder_a;
    !phase_a_alt_select && st_ff.func[0] == dpm_pkg::FN_DECODER;
  endsequence

  sequence seq_timer_b;
    !phase_b_alt_select && st_ff.func[1] == dpm_pkg::FN_TIMER;
  endsequence

  AST_RESET_FUNC_A: assert property (rst |=> st_ff.func[0] == FUNC_RST)
    else $error("phase A pin function wrong after reset");
  AST_RESET_FUNC_B: assert property (rst |=> st_ff.func[1] == FUNC_RST)
    else $error("phase B pin function wrong after reset");
  AST_RESET_PINS: assert property (rst |=> st_ff.pad_oe == 2'h0 && st_ff.pad_pu == 2'h3)
    else $error("phase pins not pulled-up inputs in reset");
  AST_RESET_SS0: assert property (rst ##1 !rst && !ss0_func_write |=> spi0_slave_select_n
    == $past(spi0_slave_select_pin_in))
    else $error("spi 0 select not routed after reset");
  AST_SPI_CLK_OUT: assert property (disable iff (rst) seq_spi_master_a |=> decoder1_phase_a_pin_oe
    && decoder1_phase_a_pin_out == $past(spi1_serial_clock_out))
    else $error("spi 1 clock not driven on phase A pin");
  AST_SPI_CLK_IN: assert property (disable iff (rst) phase_a_alt_select && !spi1_master_mode |=>
    !decoder1_phase_a_pin_oe && spi1_serial_clock_in == $past(decoder1_phase_a_pin_in))
    else $error("spi 1 clock input not taken from phase A pin");
  AST_MOSI_SLAVE: assert property (disable iff (rst) seq_spi_slave_b |=> !decoder1_phase_b_pin_oe
    && spi1_master_out_line_in == $past(decoder1_phase_b_pin_in))
    else $error("master-out line not an input in slave mode");
  AST_MOSI_MASTER: assert property (disable iff (rst) phase_b_alt_select && spi1_master_mode |=>
    decoder1_phase_b_pin_oe && decoder1_phase_b_pin_out == $past(spi1_master_out_line_out))
    else $error("master-out line not driven in master mode");
  AST_DECODER_A: assert property (disable iff (rst) seq_decoder_a |=> decoder1_phase_a
    == $past(decoder1_phase_a_pin_in) && !decoder1_phase_a_pin_oe && !spi1_serial_clock_in)
    else $error("decoder phase A not fed from pin");
  AST_TIMER_B: assert property (disable iff (rst) seq_timer_b |=> decoder1_phase_b_pin_oe
    == $past(timer_b_oe[1]) && decoder1_phase_b_pin_out == $past(timer_b_out[1]))
    else $error("timer B channel 1 not on phase B pin");
  AST_GPIO_DIR: assert property (disable iff (rst) !phase_a_alt_select && st_ff.func[0]
    == dpm_pkg::FN_GPIO |=> decoder1_phase_a_pin_oe == $past(port_c_dir[0]))
    else $error("gpio direction not applied to phase A pin");
  AST_PULLUP_C: assert property (disable iff (rst) 1'b1 |=> decoder1_phase_a_pin_pullup
    == $past(port_c_pullup_enable[0]) && decoder1_phase_b_pin_pullup == $past(port_c_pullup_enable[1]))
    else $error("port C pull-up enable not applied");
  AST_PULLUP_E: assert property (disable iff (rst) !port_e_pullup_enable[7] |=>
    !spi0_slave_select_pin_pullup)
    else $error("spi 0 select pull-up not switched off");
  AST_NONE_FLOAT: assert property (disable iff (rst) !phase_b_alt_select && st_ff.func[1]
    == dpm_pkg::FN_NONE |=> !decoder1_phase_b_pin_oe && !decoder1_phase_b)
    else $error("unassigned phase B pin not idle");
endmodule // dpm_pin_mux
`default_nettype wire

// ==== dpm_pin_mux_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpm_pin_mux_bench;
  logic mclk, rst, ss0_func_write, ss0_func_gpio, phase_a_alt_select, phase_b_alt_select, spi1_master_mode;
  logic spi1_serial_clock_out, spi1_master_out_line_out, port_e7_dir, port_e7_out, ss_drv, latched;
  logic [1:0] pin_func_write, timer_b_out, timer_b_oe, port_c_dir, port_c_out, drv_en, drv_val, lvl;
  logic [7:0] port_c_pullup_enable, port_e_pullup_enable;
  dpm_pkg::dpm_func_t pin_func_value, pin_func_a, pin_func_b, red_a, red_b;
  logic decoder1_phase_a_pin_in, decoder1_phase_b_pin_in, spi0_slave_select_pin_in;
  logic decoder1_phase_a_pin_out, decoder1_phase_a_pin_oe, decoder1_phase_a_pin_pullup, decoder1_phase_b_pin_out;
  logic decoder1_phase_b_pin_oe, decoder1_phase_b_pin_pullup, spi0_slave_select_pin_out, spi0_slave_select_pin_oe;
  logic spi0_slave_select_pin_pullup, decoder1_phase_a, decoder1_phase_b, spi1_serial_clock_in;
  logic spi1_master_out_line_in, spi0_slave_select_n, port_e7_in;
  logic [1:0] timer_b_in, port_c_in;
  int errors = 0, checked = 0, cycles = 0;
  dpm_pin_mux dut_u (.*);
  // reduced part shares every input; only its function registers are watched
  dpm_pin_mux #(.FULL_VARIANT(1'b0)) red_u (.*, .pin_func_a(red_a), .pin_func_b(red_b),
    .decoder1_phase_a_pin_out(), .decoder1_phase_a_pin_oe(), .decoder1_phase_a_pin_pullup(),
    .decoder1_phase_b_pin_out(), .decoder1_phase_b_pin_oe(), .decoder1_phase_b_pin_pullup(),
    .spi0_slave_select_pin_out(), .spi0_slave_select_pin_oe(), .spi0_slave_select_pin_pullup(),
    .decoder1_phase_a(), .decoder1_phase_b(), .timer_b_in(), .spi1_serial_clock_in(),
    .spi1_master_out_line_in(), .port_c_in(), .spi0_slave_select_n(), .port_e7_in());
  dpm_peer peer_u (.mclk(mclk), .drv_en(drv_en), .drv_val(drv_val),
    .pad_out({decoder1_phase_b_pin_out, decoder1_phase_a_pin_out}),
    .pad_oe({decoder1_phase_b_pin_oe, decoder1_phase_a_pin_oe}),
    .pad_pu({decoder1_phase_b_pin_pullup, decoder1_phase_a_pin_pullup}), .pin_lvl(lvl), .latched_bit(latched));
  // pad levels seen by the device
  assign {decoder1_phase_b_pin_in, decoder1_phase_a_pin_in} = lvl;
  assign spi0_slave_select_pin_in = spi0_slave_select_pin_oe ? spi0_slave_select_pin_out : ss_drv;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  // hang guard: about 60 cycles are expected
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // let the registered outputs catch up, then sample off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_func(input logic [1:0] pins, input dpm_pkg::dpm_func_t v);
    @(posedge mclk);
    pin_func_write <= pins;
    pin_func_value <= v;
    @(posedge mclk);
    pin_func_write <= 2'h0;
    settle(2);
  endtask
  task automatic t_reset();
    settle(3);
    chk("a oe", decoder1_phase_a_pin_oe, 4'h0);
    chk("b pu", decoder1_phase_b_pin_pullup, 4'h1);
    chk("func a", pin_func_a, dpm_pkg::FUNC_RST_FULL);
    chk("func b", pin_func_b, dpm_pkg::FN_DECODER);
    chk("red a", red_a, dpm_pkg::FN_NONE);
    chk("red b", red_b, dpm_pkg::FN_NONE);
    chk("ss_n", spi0_slave_select_n, 4'h1);
    settle(2);
    // release on an edge, after six edges with reset high
    @(posedge mclk);
    rst <= 1'b0;
    $display("reset test done");
  endtask
  task automatic t_decoder();
    @(posedge mclk);
    drv_en <= 2'h3;
    drv_val <= 2'h1;
    settle(2);
    chk("dec a", decoder1_phase_a, 4'h1);
    chk("dec b", decoder1_phase_b, 4'h0);
    @(posedge mclk);
    drv_val <= 2'h2;
    settle(2);
    chk("dec a", decoder1_phase_a, 4'h0);
    chk("dec b", decoder1_phase_b, 4'h1);
    $display("decoder test done");
  endtask
  task automatic t_spi();
    @(posedge mclk);
    drv_en <= 2'h0;
    {phase_b_alt_select, phase_a_alt_select, spi1_master_mode} <= 3'h7;
    {spi1_serial_clock_out, spi1_master_out_line_out} <= 2'h2;
    settle(2);
    chk("a oe", decoder1_phase_a_pin_oe, 4'h1);
    chk("a out", decoder1_phase_a_pin_out, 4'h1);
    chk("b oe", decoder1_phase_b_pin_oe, 4'h1);
    chk("b out", decoder1_phase_b_pin_out, 4'h0);
    // data leads the rising clock by one step, as a master would
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      {spi1_serial_clock_out, spi1_master_out_line_out} <= {1'b0, k[0] ^ 1'b1};
      @(posedge mclk);
      spi1_serial_clock_out <= 1'b1;
      settle(2);
      chk("latched", latched, {3'h0, k[0] ^ 1'b1});
    end
    @(posedge mclk);
    {spi1_master_mode, drv_en, drv_val} <= 5'h0D;
    settle(2);
    chk("slave oe", decoder1_phase_a_pin_oe, 4'h0);
    chk("clk in", spi1_serial_clock_in, 4'h1);
    chk("mosi in", spi1_master_out_line_in, 4'h0);
    chk("dec off", decoder1_phase_a, 4'h0);
    @(posedge mclk);
    {phase_b_alt_select, phase_a_alt_select} <= 2'h0;
    settle(2);
    chk("dec back", decoder1_phase_a, 4'h1);
    chk("clk idle", spi1_serial_clock_in, 4'h0);
    $display("spi test done");
  endtask
  task automatic t_func();
    wr_func(2'h3, dpm_pkg::FN_TIMER);
    @(posedge mclk);
    {timer_b_oe, timer_b_out, drv_en, drv_val} <= 8'h5A;
    settle(2);
    chk("tmr a oe", decoder1_phase_a_pin_oe, 4'h1);
    chk("tmr a out", decoder1_phase_a_pin_out, 4'h1);
    // pin A reads back its own timer drive, pin B the peer's high
    chk("tmr in", timer_b_in, 4'h3);
    wr_func(2'h3, dpm_pkg::FN_GPIO);
    @(posedge mclk);
    {port_c_dir, port_c_out, drv_en, drv_val} <= 8'hA5;
    settle(2);
    chk("gpio a oe", decoder1_phase_a_pin_oe, 4'h0);
    chk("gpio b oe", decoder1_phase_b_pin_oe, 4'h1);
    chk("gpio b out", decoder1_phase_b_pin_out, 4'h1);
    chk("gpio in", port_c_in, 4'h3);
    // unassigned pin B must stop driving and feed nothing
    wr_func(2'h2, dpm_pkg::FN_NONE);
    chk("none b oe", decoder1_phase_b_pin_oe, 4'h0);
    chk("none b dec", decoder1_phase_b, 4'h0);
    chk("none b gpio", port_c_in, 4'h1);
    $display("function test done");
  endtask
  task automatic t_pull();
    @(posedge mclk);
    port_c_pullup_enable <= 8'hFE;
    settle(2);
    chk("pu a", {decoder1_phase_b_pin_pullup, decoder1_phase_a_pin_pullup}, 4'h2);
    @(posedge mclk);
    port_c_pullup_enable <= 8'hFD;
    port_e_pullup_enable <= 8'h7F;
    settle(2);
    chk("pu b", {decoder1_phase_b_pin_pullup, decoder1_phase_a_pin_pullup}, 4'h1);
    chk("pu ss", spi0_slave_select_pin_pullup, 4'h0);
    $display("pull-up test done");
  endtask
  task automatic t_ss();
    @(posedge mclk);
    ss_drv <= 1'b0;
    settle(2);
    chk("ss_n low", spi0_slave_select_n, 4'h0);
    @(posedge mclk);
    {ss0_func_write, ss0_func_gpio, port_e7_dir, port_e7_out} <= 4'hF;
    @(posedge mclk);
    ss0_func_write <= 1'b0;
    settle(2);
    chk("ss gpio oe", spi0_slave_select_pin_oe, 4'h1);
    chk("ss gpio out", spi0_slave_select_pin_out, 4'h1);
    chk("e7 in", port_e7_in, 4'h1);
    chk("ss_n idle", spi0_slave_select_n, 4'h1);
    $display("select test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {mclk, rst, ss0_func_write, ss0_func_gpio, phase_a_alt_select, phase_b_alt_select} = 6'h10;
    {spi1_master_mode, spi1_serial_clock_out, spi1_master_out_line_out, port_e7_dir, port_e7_out} = 5'h0;
    {pin_func_write, timer_b_out, timer_b_oe, port_c_dir, port_c_out, drv_en, drv_val} = 14'h0;
    {port_c_pullup_enable, port_e_pullup_enable, ss_drv} = 17'h1FFFF;
    pin_func_value = dpm_pkg::FN_DECODER;
    t_reset();
    t_decoder();
    t_spi();
    t_func();
    t_pull();
    t_ss();
    finish_test();
  end
endmodule // dpm_pin_mux_bench
`default_nettype wire

// ==== dpm_pkg.sv ====
`default_nettype none
package dpm_pkg;
  // function a phase pin is assigned to while its alternate-select bit is clear
  typedef enum logic [1:0]
  {
    FN_DECODER = 2'h0,
    FN_TIMER = 2'h1,
    FN_GPIO = 2'h2,
    FN_NONE = 2'h3
  } dpm_func_t;

  localparam int NUM_PHASE_PINS = 2;
  localparam int PUR_WIDTH = 8;
  // pull-up enable bit positions inside the port pull-up vectors
  localparam int PC_BIT_A = 0;
  localparam int PC_BIT_B = 1;
  localparam int PE_BIT_SS = 7;
  // reset values
  localparam dpm_func_t FUNC_RST_FULL = FN_DECODER;
  localparam dpm_func_t FUNC_RST_REDUCED = FN_NONE;
  localparam logic PULLUP_RST = 1'h1;
  localparam logic SS0_GPIO_RST = 1'h0;
endpackage
`default_nettype wire

// ==== dpm_ss0_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpm_ss0_cell (
  input wire logic gpio_sel,
  input wire logic gpio_dir,
  input wire logic gpio_out,
  input wire logic pin_in,
  output logic pad_out,
  output logic pad_oe,
  output logic ss_n,
  output logic to_gpio
);
  // slave select reads inactive high whenever gpio owns the pin
  always_comb
  begin
    pad_out = gpio_sel & gpio_out;
    pad_oe = gpio_sel & gpio_dir;
    ss_n = gpio_sel | pin_in;
    to_gpio = gpio_sel & pin_in;
  end
endmodule // dpm_ss0_cell
`default_nettype wire
